/* File: common/embps_pkg.sv */
// Shared constants and types for the external memory bus phase sequencer
package embps_pkg;

	// Bus widths
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;

	// Clock output select codes; every other code switches the pin off
	localparam logic [1:0] CLOCK_OUT_PIN_SEL_EXT = 2'h0;
	localparam logic [1:0] CLOCK_OUT_PIN_SEL_PLL = 2'h1;
	localparam logic [1:0] CLOCK_OUT_PIN_SEL_OFF = 2'h2;

	// Values after reset, and the count of clock bits below the data in the synchroniser
	localparam logic [ADDR_W-1:0] ADDR_RST  = 16'h0000;
	localparam logic [DATA_W-1:0] DATA_RST  = 16'h0000;
	localparam logic [1:0]        SYNC_BITS = 2'h2;

	// Instruction cycle phases, Gray coded along the cycle
	typedef enum logic [1:0] {
		PHASE_ZERO  = 2'h0,
		PHASE_ONE   = 2'h1,
		PHASE_TWO   = 2'h3,
		PHASE_THREE = 2'h2
	} embps_phase_e;

	// One bus request from the core
	typedef struct packed {
		logic              valid;  // Access wanted this cycle
		logic              write;  // High for write, low for read
		logic              prog;   // High for program space, low for data space
		logic [ADDR_W-1:0] addr;   // External address
		logic [DATA_W-1:0] wdata;  // Write data
	} embps_req_s;

	// Pin drive state; each *_oe_n is low while the pin is driven
	typedef struct packed {
		logic [ADDR_W-1:0] ext_address;
		logic              addr_oe_n;
		logic [DATA_W-1:0] ext_data;
		logic              data_oe_n;
		logic              program_select_n;
		logic              data_select_n;
		logic              rd_n;
		logic              wr_n;
		logic              ctl_oe_n;
	} embps_pins_s;

	// All pins released during reset
	localparam embps_pins_s PINS_RST = '{
		ext_address:      ADDR_RST,
		addr_oe_n:        1'b1,
		ext_data:         DATA_RST,
		data_oe_n:        1'b1,
		program_select_n: 1'b1,
		data_select_n:    1'b1,
		rd_n:             1'b1,
		wr_n:             1'b1,
		ctl_oe_n:         1'b1
	};

endpackage

/* File: hw/embps_top.sv */
// External memory bus phase sequencer with clock source and clock output selection
`timescale 1ns/100ps
// Summary of operation
// R1: Four phases span two selected input clock periods
// R2: Core clock from squared input or PLL
// R3: Two-bit field picks clock output source
// R4: Two field settings, 2 and 3, turn clock output off
// R5: Address updates in phase zero
// R6: Read data captured leaving phase two
// R7: Write data driven phase two until zero
// R8: Data lines released without a transfer
// R9: Program select low for program accesses
// R10: Data select low for data accesses
// R11: Idle cycle drives both selects high
// R12: Write strobe low in phase one
// R13: Write strobe rises in phase three
// R14: Read strobe low entering phase one
// R15: Read strobe rises in phase three
// R16: Memory trusts address only under strobe
// R17: Memory drives data while read low
// R18: All bus pins released during reset
module embps_top
	import embps_pkg::*;
(
	input  wire logic              i_clk,            // System clock, 125 MHz
	input  wire logic              i_rst_n,          // Asynchronous reset, active low
	input  wire logic              i_ext_clock_in,   // Squared external clock pin
	input  wire logic              i_pll_clk,        // PLL master clock
	input  wire logic              i_core_src_pll,   // Core clock source: 1 PLL, 0 input
	input  wire logic [1:0]        i_clkout_select,  // Clock output select field
	input  wire embps_req_s        i_req,            // Bus request from the core
	input  wire logic [DATA_W-1:0] i_ext_data,       // Data bus pin input
	output embps_pins_s            o_pins,           // Bus pin drive state
	output logic                   o_clock_out_pin,  // Clock output pin
	output embps_phase_e           o_phase,          // Current phase
	output logic                   o_req_taken,      // Request accepted pulse
	output logic [DATA_W-1:0]      o_rdata,          // Captured read data
	output logic                   o_rdata_valid     // Read data pulse
);

	// Synchroniser stages: {data, pll clock, external clock}
	logic [DATA_W+1:0] sync1_q;      // First stage, read only by second
	logic [DATA_W+1:0] sync2_q;      // Second stage
	logic [DATA_W+1:0] sync_in;      // Raw pin inputs
	logic              ext_s;        // Synchronised input clock
	logic              pll_s;        // Synchronised PLL clock
	logic [DATA_W-1:0] data_s;       // Synchronised data bus

	// Sequencer state
	embps_phase_e      phase_q, phase_d;
	embps_req_s        cur_q, cur_d;         // Request of this cycle
	embps_pins_s       pins_q, pins_d;
	logic              sel_prev_q, sel_prev_d;
	logic              clock_out_pin_q, clock_out_pin_d;
	logic              taken_q, taken_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic              rvalid_q, rvalid_d;
	logic              sel_clk;              // Selected core clock level
	logic              step;                 // One phase per selected clock edge

	assign sync_in = {i_ext_data, i_pll_clk, i_ext_clock_in};
	assign ext_s   = sync2_q[0];
	assign pll_s   = sync2_q[1];
	assign data_s  = sync2_q[DATA_W+1:SYNC_BITS];

	// Two-flop synchroniser, one per pin bit
	genvar gi;
	generate
		for (gi = 0; gi < DATA_W + 2; gi++) begin : g_sync
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
				end else begin
					sync1_q[gi] <= sync_in[gi];
					sync2_q[gi] <= sync1_q[gi];
				end
			end
		end
	endgenerate

	// Core clock source and phase step
	always_comb begin
		sel_clk    = i_core_src_pll ? pll_s : ext_s;  // [R2]
		sel_prev_d = sel_clk;
		step       = sel_clk ^ sel_prev_q;            // Both edges step, four per two periods [R1]
	end

	// Clock output pin source
	always_comb begin
		unique case (i_clkout_select)
			CLOCK_OUT_PIN_SEL_EXT: clock_out_pin_d = ext_s;              // [R3]
			CLOCK_OUT_PIN_SEL_PLL: clock_out_pin_d = pll_s;              // [R3]
			default:      clock_out_pin_d = 1'b0;               // Pin held quiet [R4]
		endcase
	end

	// Phase sequence and bus pin next values
	always_comb begin
		phase_d  = phase_q;
		cur_d    = cur_q;
		pins_d   = pins_q;
		taken_d  = 1'b0;
		rdata_d  = rdata_q;
		rvalid_d = 1'b0;
		if (step) begin
			unique case (phase_q)
				// Enter phase zero: new cycle
				PHASE_THREE: begin
					phase_d                 = PHASE_ZERO;         // [R1]
					cur_d                   = i_req;
					taken_d                 = i_req.valid;
					pins_d.addr_oe_n        = 1'b0;
					pins_d.ctl_oe_n         = 1'b0;
					if (i_req.valid) begin
						pins_d.ext_address = i_req.addr;          // [R5]
					end
					pins_d.program_select_n = !(i_req.valid && i_req.prog);   // [R9] [R11]
					pins_d.data_select_n    = !(i_req.valid && !i_req.prog);  // [R10] [R11]
					pins_d.rd_n             = 1'b1;
					pins_d.wr_n             = 1'b1;
					pins_d.data_oe_n        = 1'b1;               // Write data released [R7] [R8]
				end
				// Enter phase one: strobes fall
				PHASE_ZERO: begin
					phase_d     = PHASE_ONE;
					pins_d.wr_n = !(cur_q.valid && cur_q.write);  // [R12]
					pins_d.rd_n = !(cur_q.valid && !cur_q.write); // Data stays input [R14]
				end
				// Enter phase two: write data out
				PHASE_ONE: begin
					phase_d          = PHASE_TWO;
					pins_d.ext_data  = cur_q.wdata;
					pins_d.data_oe_n = !(cur_q.valid && cur_q.write);  // [R7] [R8]
				end
				// Enter phase three: strobes rise, read data taken
				PHASE_TWO: begin
					phase_d     = PHASE_THREE;
					pins_d.rd_n = 1'b1;                           // [R15]
					pins_d.wr_n = 1'b1;                           // Memory latches on this rise [R13]
					if (cur_q.valid && !cur_q.write) begin
						rdata_d  = data_s;                        // [R6] [R15] [R17]
						rvalid_d = 1'b1;
					end
				end
			endcase
		end
	end

	// State registers; reset releases every bus pin
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			phase_q    <= PHASE_THREE;
			cur_q      <= '0;
			pins_q     <= PINS_RST;                           // [R18]
			sel_prev_q <= 1'b0;
			clock_out_pin_q     <= 1'b0;
			taken_q    <= 1'b0;
			rdata_q    <= DATA_RST;
			rvalid_q   <= 1'b0;
		end else begin
			phase_q    <= phase_d;
			cur_q      <= cur_d;
			pins_q     <= pins_d;
			sel_prev_q <= sel_prev_d;
			clock_out_pin_q     <= clock_out_pin_d;
			taken_q    <= taken_d;
			rdata_q    <= rdata_d;
			rvalid_q   <= rvalid_d;
		end
	end

	// Outputs straight from flops
	assign o_pins          = pins_q;
	assign o_clock_out_pin = clock_out_pin_q;
	assign o_phase         = phase_q;
	assign o_req_taken     = taken_q;
	assign o_rdata         = rdata_q;
	assign o_rdata_valid   = rvalid_q;

	// Checks on the sequencer
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	a_phase_order: assert property (step && phase_q == PHASE_ONE |=> phase_q == PHASE_TWO) // [R1]
		else $error("phase one did not advance to phase two");
	a_phase_hold: assert property (!step |=> $stable(phase_q)) // [R1]
		else $error("phase moved without a clock edge");
	a_clkout_off: assert property (i_clkout_select[1] |=> !o_clock_out_pin) // [R4]
		else $error("clock output active while disabled");
	a_addr_stable: assert property ( // [R5]
		!(step && phase_q == PHASE_THREE) |=> $stable(pins_q.ext_address))
		else $error("address changed outside phase zero");
	a_read_capture: assert property ( // [R6]
		step && phase_q == PHASE_TWO && cur_q.valid && !cur_q.write
		|=> rvalid_q && rdata_q == $past(data_s))
		else $error("read data not captured leaving phase two");
	a_data_drive: assert property ( // [R7]
		!pins_q.data_oe_n |-> cur_q.valid && cur_q.write
		&& (phase_q == PHASE_TWO || phase_q == PHASE_THREE))
		else $error("data bus driven outside write window");
	a_prog_select: assert property ( // [R9]
		!pins_q.ctl_oe_n && cur_q.valid && cur_q.prog
		|-> !pins_q.program_select_n && pins_q.data_select_n)
		else $error("program select wrong for program access");
	a_data_select: assert property ( // [R10]
		!pins_q.ctl_oe_n && cur_q.valid && !cur_q.prog
		|-> !pins_q.data_select_n && pins_q.program_select_n)
		else $error("data select wrong for data access");
	a_idle_selects: assert property ( // [R11]
		!pins_q.ctl_oe_n && !cur_q.valid
		|-> pins_q.program_select_n && pins_q.data_select_n && pins_q.rd_n && pins_q.wr_n)
		else $error("idle cycle did not hold selects high");
	a_write_strobe: assert property ( // [R12]
		!pins_q.wr_n |-> cur_q.write && phase_q inside {PHASE_ONE, PHASE_TWO})
		else $error("write strobe low outside phases one and two");
	a_strobe_rise: assert property ( // [R13]
		step && phase_q == PHASE_TWO |=> pins_q.wr_n && pins_q.rd_n)
		else $error("strobe not raised in phase three");
	a_read_strobe: assert property ( // [R14]
		!pins_q.rd_n |-> !cur_q.write && pins_q.data_oe_n
		&& phase_q inside {PHASE_ONE, PHASE_TWO})
		else $error("read strobe low outside read window");
	a_reset_release: assert property ( // [R18]
		$rose(i_rst_n) |-> pins_q.addr_oe_n && pins_q.data_oe_n && pins_q.ctl_oe_n)
		else $error("bus pins driven coming out of reset");

	c_write_cycle: cover property (step && phase_q == PHASE_ONE && cur_q.valid && cur_q.write);
	c_read_cycle:  cover property (rvalid_q);
	c_idle_cycle:  cover property (taken_d == 1'b0 && step && phase_q == PHASE_THREE);
	c_pll_clkout:  cover property (i_clkout_select == CLOCK_OUT_PIN_SEL_PLL && o_clock_out_pin);

endmodule

/* File: sim/embps_mem_model.sv */
// Behavioural static memory on the far side of the external bus
`timescale 1ns/100ps
module embps_mem_model
	import embps_pkg::*;
(
	input  wire embps_pins_s  i_pins, // Bus pins from the sequencer
	output logic [DATA_W-1:0] o_bus   // Resolved data bus level
);
	logic [DATA_W-1:0] mem [logic [ADDR_W:0]]; // Program and data spaces
	logic [DATA_W-1:0] last = 16'h0000;        // Last driven level
	wire sel = !i_pins.ctl_oe_n && !(i_pins.program_select_n && i_pins.data_select_n);
	wire [ADDR_W:0] key = {!i_pins.program_select_n, i_pins.ext_address};
	// Address and selects only trusted under a strobe; store on write rise
	always @(posedge i_pins.wr_n) begin
		if (sel && !i_pins.data_oe_n)
			mem[key] = i_pins.ext_data;
	end
	// Drive while the read strobe is low; undriven lines show no stale value
	always @* begin
		if (!i_pins.data_oe_n) begin
			o_bus = i_pins.ext_data;
			last = o_bus;
		end else if (sel && !i_pins.rd_n && mem.exists(key)) begin
			o_bus = mem[key];
			last = o_bus;
		end else
			o_bus = ~last;
	end
endmodule

/* File: sim/test_embps_top.sv */
// Self-checking bench for the external memory bus phase sequencer
`timescale 1ns/100ps
module test_embps_top
	import embps_pkg::*;
;
	typedef struct packed {
		logic        wr;
		logic        prog;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic [15:0] exp;
	} embps_row_s;
	logic         i_clk = 0, i_rst_n = 0, ext_clk = 0, pll_clk = 0, src_pll = 0;
	logic [1:0]   clk_sel = 2'h0;
	embps_req_s   req = '0;
	logic [15:0]  bus, rdata;
	embps_pins_s  pins;
	embps_phase_e phase;
	logic         clk_out, taken, rvalid;
	int           cnt = 0, t0, i, fails = 0, n_tests = 0;
	embps_row_s rows [6] = '{'{1'b1, 1'b1, 16'h1234, 16'ha5c3, 16'h0000},
		'{1'b1, 1'b0, 16'hffff, 16'h5a5a, 16'h0000}, '{1'b0, 1'b0, 16'hffff, 16'h0, 16'h5a5a},
		'{1'b0, 1'b1, 16'h1234, 16'h0, 16'ha5c3}, '{1'b1, 1'b0, 16'h0000, 16'h0001, 16'h0},
		'{1'b0, 1'b0, 16'h0000, 16'h0000, 16'h0001}};
	embps_top dut(.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ext_clock_in(ext_clk),
		.i_pll_clk(pll_clk), .i_core_src_pll(src_pll), .i_clkout_select(clk_sel),
		.i_req(req), .i_ext_data(bus), .o_pins(pins), .o_clock_out_pin(clk_out),
		.o_phase(phase), .o_req_taken(taken), .o_rdata(rdata), .o_rdata_valid(rvalid));
	embps_mem_model mem(.i_pins(pins), .o_bus(bus));
	always #4 i_clk = ~i_clk;
	// Input clock half period 5 cycles, PLL clock half period 6 cycles
	always @(negedge i_clk) begin
		cnt <= cnt + 1;
		if (cnt % 5 == 4) ext_clk <= ~ext_clk;
		if (cnt % 6 == 5) pll_clk <= ~pll_clk;
	end
	task final_report;
		if (fails == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("Error %s expected %h got %h", nm, exp, got);
			fails++;
		end
	endtask
	// Bounded wait for a phase, sampled at falling edges
	task wait_ph(input embps_phase_e p);
		for (i = 0; i < 40 && phase !== p; i++) @(negedge i_clk);
		if (phase !== p) begin
			chk("phase", 16'(p), 16'(phase));
			final_report();
		end
	endtask
	// One whole instruction cycle with a bus access, then an idle cycle
	task run_op(input embps_row_s r);
		req = '{1'b1, r.wr, r.prog, r.addr, r.wdata};
		for (i = 0; i < 60 && taken !== 1'b1; i++) @(negedge i_clk);
		if (taken !== 1'b1) begin
			chk("taken", 16'h1, 16'(taken));
			final_report();
		end
		t0 = cnt;
		req.valid = 1'b0;
		chk("addr", r.addr, pins.ext_address);
		chk("ps_n", 16'(!r.prog), 16'(pins.program_select_n));
		chk("ds_n", 16'(r.prog), 16'(pins.data_select_n));
		wait_ph(PHASE_ONE);
		chk("wr_rd", 16'({r.wr, !r.wr}), 16'({pins.rd_n, pins.wr_n}));
		wait_ph(PHASE_TWO);
		chk("data_oe_n", 16'(!r.wr), 16'(pins.data_oe_n));
		if (r.wr) chk("wdata", r.wdata, pins.ext_data);
		wait_ph(PHASE_THREE);
		chk("strobes", 16'h3, 16'({pins.rd_n, pins.wr_n}));
		if (!r.wr) chk("rdata", {r.exp}, rvalid ? rdata : 16'hdead);
		wait_ph(PHASE_ZERO);
		chk("cycle", src_pll ? 16'h18 : 16'h14, 16'(cnt - t0));
		chk("idle", 16'h7, 16'({pins.data_oe_n, pins.program_select_n, pins.data_select_n}));
	endtask
	initial begin
		repeat (2) @(negedge i_clk);
		chk("rst_oe", 16'h7, 16'({pins.addr_oe_n, pins.data_oe_n, pins.ctl_oe_n}));
		i_rst_n = 1'b1;
		foreach (rows[k]) run_op(rows[k]);
		src_pll = 1'b1;
		run_op(rows[3]);
		src_pll = 1'b0;
		// Every clock output code, checked at two opposite source levels
		for (int s = 0; s < 4; s++) begin
			clk_sel = s[1:0];
			repeat (12) @(negedge i_clk);
			repeat (2) begin
				@(negedge i_clk);
				while (s == 0 ? cnt % 5 != 3 : cnt % 6 != 3) @(negedge i_clk);
				chk("clk_out", 16'(s == 0 ? ext_clk : s == 1 ? pll_clk : 1'b0), 16'(clk_out));
			end
		end
		// Reset while write data is on the bus releases every pin
		req = '{1'b1, 1'b1, 1'b0, 16'h0042, 16'h9999};
		for (i = 0; i < 60 && pins.data_oe_n !== 1'b0; i++) @(negedge i_clk);
		chk("wr_drive", 16'h0, 16'(pins.data_oe_n));
		i_rst_n = 1'b0;
		req.valid = 1'b0;
		@(negedge i_clk);
		chk("rst_mid", 16'h7, 16'({pins.addr_oe_n, pins.data_oe_n, pins.ctl_oe_n}));
		i_rst_n = 1'b1;
		// Pins stay released while the synchroniser refills after release
		@(negedge i_clk);
		chk("rst_after", 16'h7, 16'({pins.addr_oe_n, pins.data_oe_n, pins.ctl_oe_n}));
		// Sequencer restarts on the next cycle boundary and serves a read again
		wait_ph(PHASE_ZERO);
		run_op(rows[3]);
		final_report();
	end
endmodule
